// ---- src/nvm_program_erase_control.sv ----
// flash program/erase sequencer with apb register bank
// ------------------------------------------------------------
// Summary of operation
// - bulk code erases user and executive memory
// - page code erases page holding target
// - row code programs row from ram
// - double word programs aligned word pair
// - reserved codes start nothing, flag error
// - operation select cleared only by power-on
// - power-save ignored while operation runs
// - stop-in-idle wake waits regulator delay
// - upper target register gives bits 23:16
// - lower target register gives low bits
// - key register low byte, write only
// - upper bytes of narrow registers read zero
// - upper source register gives bits 23:16
// - lower source register holds bits 15:1
// ------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none
`include "nvm_map.svh"

module nvm_program_erase_control
   import nvm_pkg::*;
#(
   parameter int OP_BULK_CYC = `NVM_T_BULK_NS / `NVM_CLK_NS,
   parameter int OP_PAGE_CYC = `NVM_T_PAGE_NS / `NVM_CLK_NS,
   parameter int OP_ROW_CYC = `NVM_T_ROW_NS / `NVM_CLK_NS,
   parameter int OP_DWORD_CYC = `NVM_T_DWORD_NS / `NVM_CLK_NS,
   parameter int WAKE_CYC = `NVM_T_VREG_NS / `NVM_CLK_NS,
   parameter int PAGE_BITS = 11,
   parameter int ROW_BITS = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic soft_reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic power_save_exec,
   output logic power_save_enter,
   input wire logic idle_mode,
   output logic flash_start,
   output logic [3:0] flash_cmd,
   output logic [23:0] flash_addr,
   output logic [23:0] flash_src_addr,
   output logic flash_busy,
   output logic flash_low_power,
   output logic flash_ready
);

   localparam int TW = 24;

   ctl_state_t r_reg;
   ctl_state_t r_next;

   logic op_busy;
   logic op_done;
   logic op_load;
   logic [TW-1:0] op_cycles;
   logic wake_busy;
   logic wake_load;
   logic setup_rd;
   logic access_wr;
   logic mapped;
   logic [15:0] rd_word;
   logic [15:0] wd;
   logic [15:0] ctl_wd;
   logic [15:0] src_wd;
   logic [3:0] op_after;
   logic op_valid;
   logic launch_ok;
   logic [TW-1:0] tgt_full;
   logic [TW-1:0] tgt_aligned;

   // ------------------------------------------------------------
   // address decode and byte lane merge
   // ------------------------------------------------------------

   // lane 0 carries bits 7:0, lane 1 bits 15:8; upper lanes are unused
   function automatic logic [15:0] merge16(
      input logic [15:0] old,
      input logic [31:0] data,
      input logic [3:0] strb
   );
      logic [15:0] res;
      res = old;
      if (strb[0]) begin
         res[7:0] = data[7:0];
      end
      if (strb[1]) begin
         res[15:8] = data[15:8];
      end
      return res;
   endfunction : merge16

   // decode the six words; anything else is an error answer
   always_comb begin
      case (paddr)
         `NVM_OFS_CONTROL, `NVM_OFS_TGT_HI, `NVM_OFS_TGT_LO,
         `NVM_OFS_KEY, `NVM_OFS_SRC_HI, `NVM_OFS_SRC_LO: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   assign setup_rd = psel & ~penable & ~pwrite;
   assign access_wr = psel & penable & pwrite & mapped;
   assign wd = merge16(16'h0000, pwdata, pstrb);

   // read mux; key reads back zero and narrow registers zero-fill
   always_comb begin
      case (paddr)
         `NVM_OFS_CONTROL: rd_word = {r_reg.wr, r_reg.wren, r_reg.wrerr,
                                      r_reg.sidl, 8'h00, r_reg.op};
         `NVM_OFS_TGT_HI: rd_word = {8'h00, r_reg.tgt_hi};
         `NVM_OFS_TGT_LO: rd_word = r_reg.tgt_lo;
         `NVM_OFS_KEY: rd_word = 16'h0000;
         `NVM_OFS_SRC_HI: rd_word = {8'h00, r_reg.src_hi};
         `NVM_OFS_SRC_LO: rd_word = {r_reg.src_lo, 1'b0};
         default: rd_word = 16'h0000;
      endcase
   end

   // ------------------------------------------------------------
   // operation code checks and durations
   // ------------------------------------------------------------

   // only four codes name an operation; the rest start nothing
   always_comb begin
      case (r_reg.op)
         `NVM_OP_BULK: op_cycles = TW'(OP_BULK_CYC);
         `NVM_OP_PAGE: op_cycles = TW'(OP_PAGE_CYC);
         `NVM_OP_ROW: op_cycles = TW'(OP_ROW_CYC);
         `NVM_OP_DWORD: op_cycles = TW'(OP_DWORD_CYC);
         default: op_cycles = TW'(1);
      endcase
   end

   assign ctl_wd = merge16({r_reg.wr, r_reg.wren, r_reg.wrerr, r_reg.sidl,
                            8'h00, r_reg.op}, pwdata, pstrb);
   assign src_wd = merge16({r_reg.src_lo, 1'b0}, pwdata, pstrb);
   assign op_after = ctl_wd[`NVM_CTL_OP_MSB:0];

   // validity judged on the code that will be in force after the write
   always_comb begin
      case (op_after)
         `NVM_OP_BULK: op_valid = 1'b1;
         `NVM_OP_PAGE: op_valid = 1'b1;
         `NVM_OP_ROW: op_valid = 1'b1;
         `NVM_OP_DWORD: op_valid = 1'b1;
         default: op_valid = 1'b0;
      endcase
   end

   // ------------------------------------------------------------
   // target address alignment per operation
   // ------------------------------------------------------------

   assign tgt_full = {r_reg.tgt_hi, r_reg.tgt_lo};

   // page and row work on whole units, so low bits are dropped
   always_comb begin
      case (op_after)
         `NVM_OP_PAGE: tgt_aligned = tgt_full & ({TW{1'b1}} << PAGE_BITS);
         `NVM_OP_ROW: tgt_aligned = tgt_full & ({TW{1'b1}} << ROW_BITS);
         `NVM_OP_DWORD: tgt_aligned = tgt_full & ({TW{1'b1}} << `NVM_DWORD_ALIGN);
         default: tgt_aligned = tgt_full;
      endcase
   end

   // a start needs the armed key, the enable bit, a real code and awake flash
   assign launch_ok = (r_reg.key == KEY_ARMED) & ctl_wd[`NVM_CTL_WREN] & op_valid
                      & flash_ready & (r_reg.state == ST_IDLE);

   // ------------------------------------------------------------
   // timers
   // ------------------------------------------------------------

   // operation length counter, loaded from the launch cycle
   nvm_cycle_timer #(
      .W(TW)
   ) op_timer_i (
      .pclk(pclk),
      .presetn(presetn),
      .load(op_load),
      .load_value(op_cycles),
      .busy(op_busy),
      .expired(op_done)
   );

   // regulator wake-up counter after leaving idle in stop-in-idle mode
   nvm_cycle_timer #(
      .W(TW)
   ) wake_timer_i (
      .pclk(pclk),
      .presetn(presetn),
      .load(wake_load),
      .load_value(TW'(WAKE_CYC)),
      .busy(wake_busy),
      .expired()
   );

   assign op_load = r_reg.start;
   assign wake_load = r_reg.idle_q & ~idle_mode & r_reg.sidl;

   // ------------------------------------------------------------
   // register writes, key sequence and operation control
   // ------------------------------------------------------------

   // next state; hardware error set is applied last so it wins over software
   always_comb begin
      r_next = r_reg;
      r_next.start = 1'b0;
      r_next.idle_q = idle_mode;
      // read data captured in setup so it stands through the access phase
      if (setup_rd) begin
         r_next.prdata = {16'h0000, rd_word};
      end
      // soft reset keeps the operation code; only power-on clears it
      if (soft_reset) begin
         r_next.key = KEY_NONE;
         r_next.wren = 1'b0;
         r_next.wrerr = 1'b0;
         r_next.sidl = 1'b0;
      end else if (access_wr) begin
         case (paddr)
            `NVM_OFS_CONTROL: begin
               r_next.wren = ctl_wd[`NVM_CTL_WREN];
               r_next.sidl = ctl_wd[`NVM_CTL_SIDL];
               r_next.wrerr = ctl_wd[`NVM_CTL_WRERR];
               r_next.key = KEY_NONE;
               // the code is frozen while an operation runs
               if (r_reg.state == ST_IDLE) begin
                  r_next.op = op_after;
               end
               if (ctl_wd[`NVM_CTL_WR] && !r_reg.wr) begin
                  if (launch_ok) begin
                     r_next.wr = 1'b1;
                     r_next.state = ST_LAUNCH;
                     r_next.start = 1'b1;
                     r_next.cmd = op_after;
                     r_next.tgt_q = tgt_aligned;
                     r_next.src_q = {r_reg.src_hi, r_reg.src_lo, 1'b0};
                  end else begin
                     r_next.wrerr = 1'b1;
                  end
               end
            end
            `NVM_OFS_TGT_HI: begin
               if (pstrb[0]) begin
                  r_next.tgt_hi = pwdata[7:0];
               end
            end
            `NVM_OFS_TGT_LO: begin
               r_next.tgt_lo = merge16(r_reg.tgt_lo, pwdata, pstrb);
            end
            `NVM_OFS_KEY: begin
               // two writes in order arm the start; anything else disarms
               if (wd[7:0] == `NVM_KEY_FIRST) begin
                  r_next.key = KEY_FIRST;
               end else if (r_reg.key == KEY_FIRST && wd[7:0] == `NVM_KEY_SECOND) begin
                  r_next.key = KEY_ARMED;
               end else begin
                  r_next.key = KEY_NONE;
               end
            end
            `NVM_OFS_SRC_HI: begin
               if (pstrb[0]) begin
                  r_next.src_hi = pwdata[7:0];
               end
            end
            `NVM_OFS_SRC_LO: begin
               r_next.src_lo = src_wd[15:1];
            end
            default: begin
            end
         endcase
      end
      // operation sequence: one launch cycle, then run until the timer ends
      case (r_reg.state)
         ST_IDLE: begin
         end
         ST_LAUNCH: begin
            r_next.state = ST_RUN;
         end
         ST_RUN: begin
            if (op_done) begin
               r_next.state = ST_IDLE;
               r_next.wr = 1'b0;
               r_next.key = KEY_NONE;
            end
         end
         default: begin
            r_next.state = ST_IDLE;
         end
      endcase
   end

   // power-on reset is the only thing that clears every field
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------

   // zero wait states: read data was loaded in the setup cycle
   assign prdata = r_reg.prdata;
   assign pready = psel & penable;
   assign pslverr = psel & penable & ~mapped;

   // power save is swallowed while flash is busy
   assign power_save_enter = power_save_exec & ~flash_busy;

   assign flash_start = r_reg.start;
   assign flash_cmd = r_reg.cmd;
   assign flash_addr = r_reg.tgt_q;
   assign flash_src_addr = r_reg.src_q;
   assign flash_busy = (r_reg.state != ST_IDLE) | op_busy;
   assign flash_low_power = r_reg.sidl & r_reg.idle_q;
   assign flash_ready = ~flash_low_power & ~wake_busy;

endmodule : nvm_program_erase_control

`default_nettype wire

// ---- inc/nvm_map.svh ----
// register offsets, field positions, codes and timing figures of the flash sequencer
`ifndef NVM_MAP_SVH
`define NVM_MAP_SVH

// ------------------------------------------------------------
// register byte offsets on the apb bus
// ------------------------------------------------------------
`define NVM_OFS_CONTROL 12'h000
`define NVM_OFS_TGT_HI 12'h004
`define NVM_OFS_TGT_LO 12'h008
`define NVM_OFS_KEY 12'h00C
`define NVM_OFS_SRC_HI 12'h010
`define NVM_OFS_SRC_LO 12'h014

// ------------------------------------------------------------
// control register fields
// ------------------------------------------------------------
`define NVM_CTL_WR 15
`define NVM_CTL_WREN 14
`define NVM_CTL_WRERR 13
`define NVM_CTL_SIDL 12
`define NVM_CTL_OP_MSB 3

// ------------------------------------------------------------
// operation codes and unlock values
// ------------------------------------------------------------
`define NVM_OP_BULK 4'hE
`define NVM_OP_PAGE 4'h3
`define NVM_OP_ROW 4'h2
`define NVM_OP_DWORD 4'h1
`define NVM_KEY_FIRST 8'h55
`define NVM_KEY_SECOND 8'hAA
`define NVM_DWORD_ALIGN 3

// ------------------------------------------------------------
// timing: clock period and default operation times in ns
// ------------------------------------------------------------
`define NVM_CLK_NS 8
`define NVM_T_BULK_NS 40000000
`define NVM_T_PAGE_NS 20000000
`define NVM_T_ROW_NS 1500000
`define NVM_T_DWORD_NS 50000
`define NVM_T_VREG_NS 30000

`endif

// ---- inc/nvm_pkg.sv ----
// types shared by the flash sequencer modules
package nvm_pkg;

   typedef enum logic [1:0] {ST_IDLE, ST_LAUNCH, ST_RUN} op_state_t;

   typedef enum logic [1:0] {KEY_NONE, KEY_FIRST, KEY_ARMED} key_state_t;

   typedef struct packed {
      op_state_t state;
      key_state_t key;
      logic wr;
      logic wren;
      logic wrerr;
      logic sidl;
      logic [3:0] op;
      logic [7:0] tgt_hi;
      logic [15:0] tgt_lo;
      logic [7:0] src_hi;
      logic [15:1] src_lo;
      logic [3:0] cmd;
      logic [23:0] tgt_q;
      logic [23:0] src_q;
      logic start;
      logic idle_q;
      logic [31:0] prdata;
   } ctl_state_t;

endpackage : nvm_pkg

// ---- src/nvm_cycle_timer.sv ----
// one-shot down counter that times flash operations and regulator wake-up
`timescale 1ns/1ns
`default_nettype none

module nvm_cycle_timer #(
   parameter int W = 24
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic load,
   input wire logic [W-1:0] load_value,
   output logic busy,
   output logic expired
);

   typedef struct packed {
      logic [W-1:0] count;
      logic run;
      logic done;
   } tmr_t;

   tmr_t r_reg;
   tmr_t r_next;

   // load restarts the count; done pulses once in the cycle after the last count, as busy falls
   always_comb begin
      r_next = r_reg;
      r_next.done = 1'b0;
      if (load) begin
         r_next.count = load_value;
         r_next.run = 1'b1;
      end else if (r_reg.run) begin
         if (r_reg.count <= W'(1)) begin
            r_next.run = 1'b0;
            r_next.done = 1'b1;
            r_next.count = '0;
         end else begin
            r_next.count = r_reg.count - W'(1);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign busy = r_reg.run;
   assign expired = r_reg.done;

endmodule : nvm_cycle_timer

`default_nettype wire

// ---- tb/nvm_program_erase_control_monitor.sv ----
// port assertions for the flash sequencer
`timescale 1ns/1ns
`default_nettype none
module nvm_program_erase_control_monitor (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic power_save_exec,
   input wire logic power_save_enter,
   input wire logic idle_mode,
   input wire logic flash_start,
   input wire logic [3:0] flash_cmd,
   input wire logic [23:0] flash_src_addr,
   input wire logic flash_busy,
   input wire logic flash_low_power,
   input wire logic flash_ready
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // completed read as seen at its last edge
   sequence s_rd;
      psel && penable && pready && !pwrite;
   endsequence
   chk_start_busy: assert property (flash_start |-> ##[0:2] flash_busy)
      else $error("busy missing after start");
   chk_op_legal: assert property (
      flash_start |-> flash_cmd inside {4'hE, 4'h3, 4'h2, 4'h1})
      else $error("start with reserved code");
   chk_src_even: assert property (flash_start |-> !flash_src_addr[0])
      else $error("odd source address");
   chk_psave_held: assert property (flash_busy && power_save_exec |-> !power_save_enter)
      else $error("power save taken while busy");
   chk_key_hidden: assert property (s_rd ##0 (paddr == 12'h00C) |-> prdata == 32'h0)
      else $error("key readable");
   chk_hi_zero: assert property (
      s_rd ##0 (paddr inside {12'h004, 12'h010}) |-> prdata[31:8] == 24'h0)
      else $error("upper bits not zero");
   chk_lo_even: assert property (s_rd ##0 (paddr == 12'h014) |-> !prdata[0])
      else $error("reserved source bit set");
   chk_wake_wait: assert property ($fell(idle_mode) && flash_low_power |=> !flash_ready [*3])
      else $error("flash ready too early");
endmodule : nvm_program_erase_control_monitor
bind nvm_program_erase_control nvm_program_erase_control_monitor nvm_program_erase_control_monitor_i (.*);
`default_nettype wire

// ---- tb/cpu_power_model.sv ----
// cpu side model issuing power-save and idle requests
`timescale 1ns/1ns
`default_nettype none
module cpu_power_model (
   input wire logic pclk,
   input wire logic psave_req,
   input wire logic idle_req,
   output logic power_save_exec = 1'b0,
   output logic idle_mode = 1'b0
);
   // software may execute power save at any time, even mid-operation
   always @(posedge pclk) begin
      power_save_exec <= psave_req;
      idle_mode <= idle_req;
   end
endmodule : cpu_power_model
`default_nettype wire

// ---- tb/nvm_program_erase_control_tb.sv ----
// self-checking bench for the flash sequencer
`timescale 1ns/1ns
`default_nettype none
`include "nvm_map.svh"
module nvm_program_erase_control_tb;
   logic pclk = 0, presetn = 0, soft_reset = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, q;
   logic [3:0] pstrb = 4'hF, flash_cmd, last_cmd = 0;
   logic pready, pslverr, psave_req = 0, idle_req = 0, power_save_exec, power_save_enter;
   logic idle_mode, flash_start, flash_busy, flash_low_power, flash_ready;
   logic [23:0] flash_addr, flash_src_addr;
   int num_errors = 0, tests_run = 0, starts = 0, n, takes = 0;
   logic [23:0] last_addr = 0, last_src = 0;
   logic err_q;
   logic [23:0] addrs [4] = '{24'hFFA5C3, 24'hFFA000, 24'hFFA500, 24'hFFA5C0};
   logic [3:0] ops [4] = '{`NVM_OP_BULK, `NVM_OP_PAGE, `NVM_OP_ROW, `NVM_OP_DWORD};
   always #4 pclk = ~pclk;
   // short operation times keep the run brief
   nvm_program_erase_control #(.OP_BULK_CYC(40), .OP_PAGE_CYC(30), .OP_ROW_CYC(20),
      .OP_DWORD_CYC(10), .WAKE_CYC(6)) nvm_program_erase_control_i (.*);
   cpu_power_model cpu_power_model_i (.*);
   always @(posedge pclk) begin
      if (flash_start === 1'b1) begin
         starts <= starts + 1;
         last_cmd <= flash_cmd;
         last_addr <= flash_addr;
         last_src <= flash_src_addr;
      end
      if (power_save_enter === 1'b1) takes <= takes + 1;
   end
   task conclude;
      $display("errors %0d of %0d checks", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : conclude
   task chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   // apb transfer, held until pready is sampled high
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      k = 0;
      do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 50);
      q = prdata;
      err_q = pslverr;
      psel <= 0;
      penable <= 0;
      if (k >= 50) begin num_errors++; conclude(); end
      @(posedge pclk);
   endtask : xfer
   task wr_rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] e);
      xfer(1, a, d);
      xfer(0, a, 0);
      chk(q, e);
   endtask : wr_rd
   task run(input logic [3:0] op, input logic key);
      xfer(1, `NVM_OFS_CONTROL, 32'h4000 | op);
      if (key) begin xfer(1, `NVM_OFS_KEY, 32'h55); xfer(1, `NVM_OFS_KEY, 32'hAA); end
      xfer(1, `NVM_OFS_CONTROL, 32'hC000 | op);
   endtask : run
   // poll the start bit with a bounded count
   task wait_done;
      n = 0;
      do begin xfer(0, `NVM_OFS_CONTROL, 0); n++; end while (q[15] !== 1'b0 && n < 100);
      if (n >= 100) begin num_errors++; conclude(); end
   endtask : wait_done
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      xfer(0, `NVM_OFS_CONTROL, 0);
      chk(q & 32'hF, 0);
      wr_rd(`NVM_OFS_TGT_HI, 32'hFFFFFFFF, 32'hFF);
      wr_rd(`NVM_OFS_TGT_LO, 32'h0000A5C3, 32'hA5C3);
      wr_rd(`NVM_OFS_KEY, 32'hFFFFFFFF, 0);
      wr_rd(`NVM_OFS_SRC_HI, 32'hFFFFFFFF, 32'hFF);
      wr_rd(`NVM_OFS_SRC_LO, 32'h0000FFFE, 32'hFFFE);
      $display("test registers done");
      foreach (ops[i]) begin
         run(ops[i], 1);
         psave_req <= 1;
         @(posedge pclk);
         psave_req <= 0;
         wait_done;
         chk({28'h0, last_cmd}, {28'h0, ops[i]});
         chk({8'h0, last_addr}, {8'h0, addrs[i]});
      end
      chk({8'h0, last_src}, 32'hFFFFFE);
      chk(32'(takes), 0);
      psave_req <= 1;
      @(posedge pclk);
      psave_req <= 0;
      repeat (2) @(posedge pclk);
      chk(32'(takes), 1);
      $display("test operations done");
      run(4'h1, 0);
      wait_done;
      chk(32'(starts), 4);
      chk(32'(q[13]), 1);
      run(4'h0, 1);
      wait_done;
      chk(32'(starts), 4);
      chk(32'(q[13]), 1);
      xfer(0, 12'h018, 0);
      chk({31'h0, err_q}, 1);
      chk(q, 0);
      $display("test refusals done");
      xfer(1, `NVM_OFS_CONTROL, 32'h1002);
      soft_reset <= 1;
      @(posedge pclk);
      soft_reset <= 0;
      xfer(0, `NVM_OFS_CONTROL, 0);
      chk(q, 2);
      xfer(1, `NVM_OFS_CONTROL, 32'h1002);
      idle_req <= 1;
      repeat (10) @(posedge pclk);
      chk({31'h0, flash_low_power}, 1);
      idle_req <= 0;
      n = 0;
      do begin @(posedge pclk); n++; end while (flash_ready !== 1'b1 && n < 100);
      chk({31'h0, flash_ready}, 1);
      chk(32'(n > 6), 1);
      $display("test reset and idle done");
      conclude();
   end
endmodule : nvm_program_erase_control_tb
`default_nettype wire
